// *** core/bus_error_reporting.sv ***
// Error detection, memory correction control and system/parity error signalling.
`default_nettype none
// Notes on behaviour
// - System error line drives only while system error signalling is enabled.
// - Single-bit and multi-bit memory errors raise system error, each by its own enable.
// - Memory errors during memory initialisation are ignored.
// - Target abort on own PCI cycle gives a one-clock system error.
// - Target abort on own AGP cycle gives a one-clock system error.
// - PCI address or data parity errors may raise system error.
// - AGP address or data parity errors may raise system error.
// - Hit on invalid translation table entry may raise system error.
// - AGP master access outside aperture may raise system error.
// - Parity error line drives only while parity error signalling is enabled.
// - Integrity mode none: no memory checking and no memory reports.
// - Correcting modes report multi-bit errors as parity errors.
// - Correct-only mode corrects read data but never writes back.
// - Hardware mode corrects and writes the corrected word back.
// - Hardware mode: repeat error at written-back location reported as parity error.
module bus_error_reporting
  import bus_error_pkg::*;
#(
  parameter int unsigned AW = ADDR_WIDTH,
  parameter int unsigned DW = DATA_WIDTH
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serr_enable,
  input wire logic perr_enable,
  input wire logic [ERROR_CMD_WIDTH-1:0] error_command_reg,
  input wire integrity_mode_t integrity_mode,
  input wire logic mem_init_busy,
  input wire logic pci_parity_serr_en,
  input wire logic agp_parity_serr_en,
  input wire logic gart_serr_en,
  input wire logic agp_range_serr_en,
  input wire logic mem_rd_valid,
  input wire logic [AW-1:0] mem_rd_addr,
  input wire logic [DW-1:0] mem_rd_data,
  input wire logic mem_single_err,
  input wire logic mem_multi_err,
  input wire logic [$clog2(DW)-1:0] mem_err_bit,
  input wire logic pci_target_abort,
  input wire logic agp_target_abort,
  input wire logic pci_parity_err,
  input wire logic agp_parity_err,
  input wire logic gart_invalid_hit,
  input wire logic agp_outside_aperture,
  output logic corr_valid,
  output logic [DW-1:0] corr_data,
  output logic wb_valid,
  output logic [AW-1:0] wb_addr,
  output logic [DW-1:0] wb_data,
  output logic mem_parity_report,
  output logic serr_n_o,
  output logic serr_n_oe,
  output logic perr_n_o,
  output logic perr_n_oe
);
  logic checking;
  logic sbe_seen;
  logic mbe_seen;
  logic [DW-1:0] fixed_data;
  logic [TRACK_IDX_WIDTH-1:0] idx;
  logic [TRACK_IDX_WIDTH-1:0] idx_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] fixed_q;
  logic sbe_q;
  logic mbe_q;
  logic stage_valid;
  logic track_valid;
  logic [AW-1:0] track_addr;
  logic repeat_hit;
  logic sbe_event;
  logic mbe_event;
  logic abort_pulse;
  logic level_event;
  logic [1:0] serr_hold;
  logic serr_active;
  logic track_wr;
  logic track_clr;
  logic sbe_cmd_event;
  logic mbe_cmd_event;
  logic pci_parity_event;
  logic agp_parity_event;
  logic gart_event;
  logic range_event;
  logic perr_active;

  assign checking = mem_rd_valid && !mem_init_busy &&
                    (integrity_mode != INTEGRITY_NONE);
  assign sbe_seen = checking && mem_single_err && !mem_multi_err;
  assign mbe_seen = checking && mem_multi_err;
  assign fixed_data = mem_rd_data ^ (DW'(1) << mem_err_bit);
  assign idx = mem_rd_addr[TRACK_IDX_WIDTH-1:0];

  error_track_mem #(
    .DEPTH(TRACK_DEPTH),
    .IDX_W(TRACK_IDX_WIDTH),
    .AW(AW)
  ) i_error_track_mem (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .wr_en(track_wr),
    .clr_en(track_clr),
    .wr_idx(idx_q),
    .wr_addr(addr_q),
    .rd_idx(idx),
    .rd_valid(track_valid),
    .rd_addr(track_addr)
  );

  // Stage one read so the tracking memory lookup is available.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage_valid <= 1'b0;
      sbe_q <= 1'b0;
      mbe_q <= 1'b0;
      addr_q <= '0;
      idx_q <= '0;
      fixed_q <= '0;
    end else begin
      stage_valid <= checking;
      sbe_q <= sbe_seen;
      mbe_q <= mbe_seen;
      addr_q <= mem_rd_addr;
      idx_q <= idx;
      fixed_q <= sbe_seen ? fixed_data : mem_rd_data;
    end
  end

  assign repeat_hit = track_valid && (track_addr == addr_q);
  // A repeat single-bit error after write-back is a hard error.
  assign sbe_event = stage_valid && sbe_q &&
                     !(integrity_mode == INTEGRITY_HW_ECC && repeat_hit);
  assign mbe_event = stage_valid && (mbe_q ||
                     (sbe_q && integrity_mode == INTEGRITY_HW_ECC && repeat_hit));

  // The address is remembered at the stage, while its index still stands in idx_q.
  assign track_wr = sbe_event && (integrity_mode == INTEGRITY_HW_ECC);
  // A clean read of a remembered address forgets it.
  assign track_clr = stage_valid && !sbe_q && !mbe_q && repeat_hit;

  // Corrected read data path.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      corr_valid <= 1'b0;
      corr_data <= '0;
    end else begin
      corr_valid <= stage_valid;
      corr_data <= fixed_q;
    end
  end

  // Write-back of corrected words in hardware mode only.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wb_valid <= 1'b0;
      wb_addr <= '0;
      wb_data <= '0;
    end else begin
      wb_valid <= track_wr;
      wb_addr <= addr_q;
      wb_data <= fixed_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_parity_report <= 1'b0;
    end else begin
      mem_parity_report <= mbe_event;
    end
  end

  assign abort_pulse = pci_target_abort || agp_target_abort;
  assign sbe_cmd_event = sbe_event && error_command_reg[ERROR_CMD_SBE_BIT];
  assign mbe_cmd_event = mbe_event && error_command_reg[ERROR_CMD_MBE_BIT];
  assign pci_parity_event = pci_parity_err && pci_parity_serr_en;
  assign agp_parity_event = agp_parity_err && agp_parity_serr_en;
  assign gart_event = gart_invalid_hit && gart_serr_en;
  assign range_event = agp_outside_aperture && agp_range_serr_en;
  // Every enabled source other than an abort feeds the held system error request.
  assign level_event = sbe_cmd_event || mbe_cmd_event || pci_parity_event ||
                       agp_parity_event || gart_event || range_event;

  // Hold non-abort events for the least pulse length.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serr_hold <= SERR_CNT_RESET;
    end else if (level_event) begin
      serr_hold <= 2'(SERR_MIN_CYCLES);
    end else if (serr_hold != SERR_CNT_RESET) begin
      serr_hold <= serr_hold - 2'h1;
    end
  end

  // Aborts and the other sources pass straight through; a held count of 1 never passes the greater-than-1 compare, so it never extends the line.
  assign serr_active = serr_enable && (abort_pulse || level_event || serr_hold > 2'h1);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serr_n_o <= 1'b1;
      serr_n_oe <= 1'b0;
    end else begin
      serr_n_o <= !serr_active;
      serr_n_oe <= serr_active;
    end
  end

  // Parity error line reports PCI parity errors and uncorrectable memory words.
  assign perr_active = perr_enable && (pci_parity_err || mbe_event);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      perr_n_o <= 1'b1;
      perr_n_oe <= 1'b0;
    end else begin
      perr_n_o <= !perr_active;
      perr_n_oe <= perr_active;
    end
  end

  // These check the system and parity error lines.
  AST_SERR_GATED: assert property (@(posedge mclk) disable iff (sys_rst)
    !serr_enable |=> serr_n_o && !serr_n_oe)
    else $error("system error driven while disabled");

  AST_PERR_GATED: assert property (@(posedge mclk) disable iff (sys_rst)
    !perr_enable |=> perr_n_o && !perr_n_oe)
    else $error("parity error driven while disabled");

  AST_ABORT_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && pci_target_abort |=> !serr_n_o)
    else $error("abort not signalled");

  AST_AGP_ABORT: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && agp_target_abort |=> !serr_n_o)
    else $error("agp abort not signalled");

  AST_ABORT_ONE_CLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
    abort_pulse ##1 (!abort_pulse && !level_event && serr_hold <= 2'h1) |=> serr_n_o)
    else $error("abort pulse longer than one clock");

  AST_SBE_SERR: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && sbe_event && error_command_reg[ERROR_CMD_SBE_BIT] |=> !serr_n_o)
    else $error("single-bit error not signalled");

  AST_MBE_SERR: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && mbe_event && error_command_reg[ERROR_CMD_MBE_BIT] |=> !serr_n_o)
    else $error("multi-bit error not signalled");

  AST_PCI_PARITY: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && pci_parity_err && pci_parity_serr_en |=> !serr_n_o)
    else $error("pci parity error not signalled");

  AST_AGP_PARITY: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && agp_parity_err && agp_parity_serr_en |=> !serr_n_o)
    else $error("agp parity error not signalled");

  AST_GART: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && gart_invalid_hit && gart_serr_en |=> !serr_n_o && serr_n_oe)
    else $error("table error not signalled");

  AST_RANGE: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_enable && agp_outside_aperture && agp_range_serr_en |=> !serr_n_o)
    else $error("aperture error not signalled");

  AST_SERR_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
    serr_n_oe != serr_n_o)
    else $error("system error enable and level disagree");

  AST_RESET_CLEAR: assert property (@(posedge mclk)
    sys_rst |=> serr_n_o && perr_n_o && !wb_valid && !mem_parity_report)
    else $error("reset left an error pending");

  AST_PERR_PAIR: assert property (@(posedge mclk) disable iff (sys_rst)
    perr_n_oe != perr_n_o)
    else $error("parity error enable and level disagree");

  AST_PERR_PCI: assert property (@(posedge mclk) disable iff (sys_rst)
    perr_enable && pci_parity_err |=> !perr_n_o)
    else $error("pci parity error not on parity line");

  // These check the memory integrity path.
  AST_INIT_IGNORE: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_init_busy |=> !stage_valid)
    else $error("error taken during init");

  AST_NONE_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
    integrity_mode == INTEGRITY_NONE |=> !stage_valid)
    else $error("check in none mode");

  AST_NO_WB_CORRECT_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    integrity_mode == INTEGRITY_CORRECT_ONLY |=> !wb_valid)
    else $error("write-back in correct-only");

  AST_WB_HW: assert property (@(posedge mclk) disable iff (sys_rst)
    sbe_event && integrity_mode == INTEGRITY_HW_ECC |=> wb_valid && wb_addr == $past(addr_q))
    else $error("missing write-back");

  AST_MBE_REPORT: assert property (@(posedge mclk) disable iff (sys_rst)
    mbe_event |=> mem_parity_report)
    else $error("multi-bit not reported");

  AST_REPEAT_REPORT: assert property (@(posedge mclk) disable iff (sys_rst)
    stage_valid && sbe_q && repeat_hit && integrity_mode == INTEGRITY_HW_ECC
    |=> mem_parity_report && !wb_valid)
    else $error("repeat error not reported");
endmodule
`default_nettype wire

// *** core/error_track_mem.sv ***
// Small memory remembering addresses already written back after a single-bit error.
`default_nettype none
module error_track_mem #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned IDX_W = 4,
  parameter int unsigned AW = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic clr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic rd_valid,
  output logic [AW-1:0] rd_addr
);
  logic [AW-1:0] tag_mem [DEPTH];
  logic [DEPTH-1:0] valid_bits;

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      tag_mem[wr_idx] <= wr_addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      valid_bits <= '0;
    end else if (wr_en) begin
      valid_bits[wr_idx] <= 1'b1;
    end else if (clr_en) begin
      valid_bits[wr_idx] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rd_valid <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_valid <= valid_bits[rd_idx];
      rd_addr <= tag_mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

// *** include/bus_error_pkg.sv ***
// Package of constants and types for the bus error reporting block.
`default_nettype none
package bus_error_pkg;
  // Memory integrity mode encodings.
  typedef enum logic [1:0] {
    INTEGRITY_NONE = 2'b00,
    INTEGRITY_CORRECT_ONLY = 2'b01,
    INTEGRITY_HW_ECC = 2'b10
  } integrity_mode_t;
  // Error command register field positions.
  localparam int unsigned ERROR_CMD_WIDTH = 2;
  localparam int unsigned ERROR_CMD_SBE_BIT = 0;
  localparam int unsigned ERROR_CMD_MBE_BIT = 1;
  // Memory word widths and repeat-error tracking memory.
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 64;
  localparam int unsigned SYND_WIDTH = 8;
  localparam int unsigned TRACK_DEPTH = 16;
  localparam int unsigned TRACK_IDX_WIDTH = 4;
  // Clock period and least system error pulse length.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SERR_MIN_NS = 50;
  localparam int unsigned SERR_MIN_CYCLES =
    (SERR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SERR_CNT_RESET = 2'h0;
endpackage
`default_nettype wire

// *** test/bus_error_reporting_test.sv ***
// Self-checking testbench for the bus error reporting block.
`default_nettype none
module bus_error_reporting_test
  import bus_error_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic serr_enable = 1'b1, perr_enable = 1'b1, mem_init_busy = 1'b0;
  logic [1:0] error_command_reg = 2'h3;
  integrity_mode_t integrity_mode = INTEGRITY_HW_ECC;
  logic [3:0] src_en = 4'hf;
  logic [5:0] ev, err_bit;
  logic rd_valid, single_err, multi_err, corr_valid, wb_valid, rep;
  logic [7:0] rd_addr, wb_addr, wa;
  logic [63:0] rd_data, corr_data, wb_data, cd, wd;
  logic serr_n_o, serr_n_oe, perr_n_o, perr_n_oe;
  logic [63:0] dat = 64'h0123456789abcdef;
  int fails = 0, checks_done = 0, s, p, c, w, r;
  always #25 mclk = ~mclk;
  far_side_model i_far_side_model (.mclk(mclk), .ev(ev), .rd_valid(rd_valid),
    .rd_addr(rd_addr), .rd_data(rd_data), .single_err(single_err),
    .multi_err(multi_err), .err_bit(err_bit));
  bus_error_reporting i_bus_error_reporting (.mclk(mclk), .sys_rst(sys_rst),
    .serr_enable(serr_enable), .perr_enable(perr_enable),
    .error_command_reg(error_command_reg), .integrity_mode(integrity_mode),
    .mem_init_busy(mem_init_busy), .pci_parity_serr_en(src_en[0]),
    .agp_parity_serr_en(src_en[1]), .gart_serr_en(src_en[2]), .agp_range_serr_en(src_en[3]),
    .mem_rd_valid(rd_valid), .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
    .mem_single_err(single_err), .mem_multi_err(multi_err), .mem_err_bit(err_bit),
    .pci_target_abort(ev[0]), .agp_target_abort(ev[1]), .pci_parity_err(ev[2]),
    .agp_parity_err(ev[3]), .gart_invalid_hit(ev[4]), .agp_outside_aperture(ev[5]),
    .corr_valid(corr_valid), .corr_data(corr_data), .wb_valid(wb_valid), .wb_addr(wb_addr),
    .wb_data(wb_data), .mem_parity_report(rep), .serr_n_o(serr_n_o),
    .serr_n_oe(serr_n_oe), .perr_n_o(perr_n_o), .perr_n_oe(perr_n_oe));
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // Counts the cycles in which each output is active over a window of n clocks.
  task automatic obs(input int n);
    {s, p, c, w, r} = '0;
    repeat (n) begin
      if (serr_n_oe !== 1'b0 || serr_n_o !== 1'b1) s++;
      if (perr_n_oe !== 1'b0 || perr_n_o !== 1'b1) p++;
      if (corr_valid !== 1'b0) c++;
      if (rep !== 1'b0) r++;
      if (corr_valid === 1'b1) cd = corr_data;
      if (wb_valid !== 1'b0) w++;
      if (wb_valid === 1'b1) {wa, wd} = {wb_addr, wb_data};
      @(posedge mclk) #2;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic sb, input logic mb, input logic [5:0] b);
    i_far_side_model.mem_read(a, dat, sb, mb, b);
    obs(6);
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    obs(2);
    chk(s == 0 && p == 0, "outputs driven after reset");
    for (int i = 0; i < 6; i++) begin
      i_far_side_model.fire(i);
      obs(4);
      chk(s == 1, "system error not one clock");
      if (i != 3) chk(p == (i == 2), "parity error line wrong");
    end
    @(posedge mclk) #1 serr_enable = 1'b0;
    i_far_side_model.fire(0);
    obs(4);
    chk(s == 0, "system error while disabled");
    @(posedge mclk) #1 {serr_enable, perr_enable} = 2'b10;
    i_far_side_model.fire(2);
    obs(4);
    chk(p == 0 && s == 1, "parity error while disabled");
    @(posedge mclk) #1 {perr_enable, src_en[0]} = 2'b10;
    i_far_side_model.fire(2);
    obs(4);
    chk(s == 0, "parity source enable ignored");
    @(posedge mclk) #1 src_en[0] = 1'b1;
    integrity_mode = INTEGRITY_NONE;
    rd(8'h03, 1'b0, 1'b1, 6'h00);
    chk(s == 0 && c == 0 && r == 0 && p == 0, "report in mode none");
    @(posedge mclk) #1 integrity_mode = INTEGRITY_CORRECT_ONLY;
    rd(8'h03, 1'b1, 1'b0, 6'h05);
    chk(c == 1 && cd === (dat ^ 64'h20) && w == 0 && s == 1, "correct-only read");
    @(posedge mclk) #1 error_command_reg = 2'h2;
    rd(8'h03, 1'b1, 1'b0, 6'h05);
    chk(s == 0, "single-bit enable ignored");
    rd(8'h04, 1'b0, 1'b1, 6'h00);
    chk(r == 1 && s == 1, "multi-bit not reported");
    @(posedge mclk) #1 integrity_mode = INTEGRITY_HW_ECC;
    error_command_reg = 2'h3;
    mem_init_busy = 1'b1;
    rd(8'h05, 1'b1, 1'b0, 6'h07);
    chk(s == 0 && r == 0, "error during initialisation");
    @(posedge mclk) #1 mem_init_busy = 1'b0;
    rd(8'h06, 1'b1, 1'b0, 6'h07);
    chk(w == 1 && wa === 8'h06 && wd === (dat ^ 64'h80) && c == 1, "write-back");
    rd(8'h06, 1'b1, 1'b0, 6'h07);
    chk(r == 1 && w == 0 && s == 1, "repeat error not reported");
    rd(8'h06, 1'b0, 1'b0, 6'h00);
    chk(c == 1 && cd === dat && w == 0 && r == 0 && s == 0, "clean read");
    rd(8'h06, 1'b1, 1'b0, 6'h07);
    chk(w == 1 && r == 0, "clean read did not forget address");
    @(posedge mclk) #1 sys_rst = 1'b1;
    @(posedge mclk) #1 sys_rst = 1'b0;
    obs(2);
    chk(s == 0 && p == 0 && w == 0 && r == 0, "outputs driven after second reset");
    rd(8'h06, 1'b1, 1'b0, 6'h07);
    chk(w == 1 && r == 0 && s == 1, "reset did not clear tracking");
    tally_and_finish();
  end
  initial begin
    #(2000 * 50);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// *** test/far_side_model.sv ***
// Model of the bus agents and memory controller that hand error events to the block.
`default_nettype none
module far_side_model
  import bus_error_pkg::*;
(
  input wire logic mclk,
  output logic [5:0] ev,
  output logic rd_valid,
  output logic [ADDR_WIDTH-1:0] rd_addr,
  output logic [DATA_WIDTH-1:0] rd_data,
  output logic single_err,
  output logic multi_err,
  output logic [5:0] err_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ev = '0;
    rd_valid = 1'b0;
    rd_addr = '0;
    rd_data = '0;
    single_err = 1'b0;
    multi_err = 1'b0;
    err_bit = '0;
  end
  task automatic fire(input int i);
    @(posedge mclk) #1 ev[i] = 1'b1;
    @(posedge mclk) #1 ev = '0;
  endtask
  // Outside a read the lines show the inverse of the last value, so nothing stale can match.
  task automatic mem_read(input logic [7:0] a, input logic [63:0] d, input logic s,
                          input logic m, input logic [5:0] b);
    @(posedge mclk) #1 rd_valid = 1'b1;
    rd_addr = a;
    rd_data = d;
    single_err = s;
    multi_err = m;
    err_bit = b;
    @(posedge mclk) #1 rd_valid = 1'b0;
    rd_addr = ~a;
    rd_data = ~d;
    single_err = ~s;
    multi_err = ~m;
    err_bit = ~b;
  endtask
endmodule
`default_nettype wire
